// [dv/cpu_core_model.sv]
`timescale 1ns/1ps

module cpu_core_model (
	// Clock and commands from the bench
	input  wire logic       clock_i,
	input  wire logic [2:0] tbl_req_i,
	input  wire logic       upd_req_i,
	// Core signals toward the block
	output logic [7:0]      chip_program_control_o,
	output logic            cpu_idle_o,
	output logic            tbl_read_o,
	output logic            fetch_external_o,
	output logic            tbl_addr_internal_o
);
	logic [2:0] step_ff = 3'h0;

	// Update sequence step counter
	always_ff @(posedge clock_i) begin
		if (upd_req_i) begin
			step_ff <= 3'h6;
		end else if (step_ff != 3'h0) begin
			step_ff <= step_ff - 3'h1;
		end
	end

	// Control value leads idle by two cycles, never after it
	assign chip_program_control_o = (step_ff != 3'h0) ? 8'h01 : 8'h00;
	assign cpu_idle_o = (step_ff != 3'h0) && (step_ff < 3'h5);
	// Table read request passed straight through
	assign {tbl_read_o, fetch_external_o, tbl_addr_internal_o} = tbl_req_i;
endmodule // cpu_core_model

// [dv/flash_security_properties.sv]
`timescale 1ns/1ps
`include "flash_security_map.svh"

module flash_security_checker (
	// Clock, reset and bus
	input wire logic        clock_i,
	input wire logic        sys_rst_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] prdata_o,
	input wire logic        pready_o,
	input wire logic        pslverr_o,
	// Pins, core and results
	input wire logic        ext_rst_i,
	input wire logic        reboot_pin_pair_low_i,
	input wire logic        reboot_single_pin_i,
	input wire logic        fetch_external_i,
	input wire logic        tbl_read_i,
	input wire logic        tbl_addr_internal_i,
	input wire logic        tbl_internal_ok_o,
	input wire logic        flash_access_ok_o,
	input wire logic        boot_loader_o,
	input wire logic        cpu_hold_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (sys_rst_i);

	// Setup cycles, split by direction
	logic setup_rd;
	logic setup_wr;
	assign setup_rd = psel_i && !penable_i && !pwrite_i;
	assign setup_wr = psel_i && !penable_i && pwrite_i;

	a_id_read_fixed: assert property (setup_rd && paddr_i == `ADDR_MAKER_ID
		|=> pready_o && (pslverr_o || prdata_o == {24'h0, `MAKER_ID_VAL}))
		else $error("maker id read wrong");
	a_id_write_refused: assert property (setup_wr && paddr_i == `ADDR_PART_ID
		|=> pready_o && pslverr_o) else $error("id write not refused");
	a_locked_read_denied: assert property (setup_rd
		&& paddr_i == `ADDR_SECURITY && !flash_access_ok_o
		|=> pslverr_o && prdata_o == 32'h0) else $error("locked read leaked");
	a_int_fetch_allowed: assert property (tbl_read_i && !fetch_external_i
		|=> tbl_internal_ok_o) else $error("internal table read blocked");
	a_ext_block_cause: assert property (!tbl_internal_ok_o
		|-> $past(tbl_read_i && fetch_external_i && tbl_addr_internal_i))
		else $error("table read blocked without cause");
	a_boot_frozen: assert property (!ext_rst_i [*6]
		|-> $stable(boot_loader_o)) else $error("boot choice moved");
	a_no_req_app: assert property ((cpu_hold_o && reboot_pin_pair_low_i
		&& reboot_single_pin_i) [*6] |-> !boot_loader_o)
		else $error("loader boot without request");
	a_cpu_released: assert property (!ext_rst_i [*6] |-> !cpu_hold_o)
		else $error("cpu held without reset");
endmodule // flash_security_checker

bind flash_security_option_bits flash_security_checker checker_inst (
	.clock_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
	.prdata_o, .pready_o, .pslverr_o, .ext_rst_i, .reboot_pin_pair_low_i,
	.reboot_single_pin_i, .fetch_external_i, .tbl_read_i,
	.tbl_addr_internal_i, .tbl_internal_ok_o, .flash_access_ok_o,
	.boot_loader_o, .cpu_hold_o);

// [dv/test_flash_security_option_bits.sv]
`timescale 1ns/1ps
`include "flash_security_map.svh"

module test_flash_security_option_bits import flash_security_pkg::*;;
	// Stimulus, results and bookkeeping
	logic        clock_i = 1'b0, sys_rst_i = 1'b1;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rnd;
	logic        pready, pslverr, ext_rst = 1'b0, upd_req = 1'b0;
	logic        pl = 1'b1, ph = 1'b1, sg = 1'b1;
	logic [2:0]  tbl_req = 3'h0;
	logic [7:0]  ctl;
	logic        idle, fext, trd, tint, tok, acc_ok, boot, hold, clkhi;
	logic [33:0] e, exp_q[$];
	logic [3:0]  cases[5] = '{4'h3, 4'hA, 4'hD, 4'h6, 4'hE};
	int          seed = 55, err_count = 0, n_checks = 0;

	flash_security_option_bits flash_security_option_bits_inst (
		.clock_i(clock_i), .sys_rst_i(sys_rst_i), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
		.pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .ext_rst_i(ext_rst),
		.reboot_pin_pair_low_i(pl), .reboot_pin_pair_high_i(ph),
		.reboot_single_pin_i(sg), .chip_program_control_i(ctl),
		.cpu_idle_i(idle), .fetch_external_i(fext), .tbl_read_i(trd),
		.tbl_addr_internal_i(tint), .tbl_internal_ok_o(tok),
		.flash_access_ok_o(acc_ok), .boot_loader_o(boot),
		.cpu_hold_o(hold), .clk_range_high_o(clkhi));

	cpu_core_model cpu_core_model_inst (.clock_i(clock_i),
		.tbl_req_i(tbl_req), .upd_req_i(upd_req),
		.chip_program_control_o(ctl), .cpu_idle_o(idle), .tbl_read_o(trd),
		.fetch_external_o(fext), .tbl_addr_internal_o(tint));

	// ----------------------------------------------------------------
	// Clock, compare and bus tasks
	// ----------------------------------------------------------------
	initial forever #2 clock_i = ~clock_i;

	task automatic chk(input logic [31:0] seen, exp, input string what);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %s exp %h seen %h", what, exp, seen);
		end
	endtask

	// Request held until pready is seen at a rising edge
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, input logic [33:0] x);
		@(posedge clock_i);
		exp_q.push_back(x);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock_i);
		penable <= 1'b1;
		// Only the watchdog ends a wait that never sees pready
		do @(posedge clock_i); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d, input er);
		apb(1'b1, a, d, {1'b0, er, 32'h0});
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] d, input er);
		apb(1'b0, a, 32'h0, {1'b1, er, d});
	endtask

	// Pins picked during reset, then scrambled to show the freeze
	task automatic reboot(input logic [2:0] pins, input logic exp);
		@(posedge clock_i);
		ext_rst <= 1'b1;
		{pl, ph, sg} <= pins;
		repeat (8) @(posedge clock_i);
		ext_rst <= 1'b0;
		repeat (8) @(posedge clock_i);
		rnd = $random(seed);
		{pl, ph, sg} <= rnd[2:0];
		repeat (4) @(posedge clock_i);
		@(negedge clock_i);
		chk({31'h0, boot}, {31'h0, exp}, "boot_loader");
		chk({31'h0, hold}, 32'h0, "cpu_hold");
		@(posedge clock_i);
		{pl, ph, sg} <= 3'h7;
	endtask

	// First request is the blocked combination, the rest random
	task automatic tbl(input logic open);
		logic [2:0] v;
		for (int k = 0; k < 8; k++) begin
			@(posedge clock_i);
			rnd = $random(seed);
			v = (k == 0) ? 3'h7 : rnd[2:0];
			tbl_req <= v;
			@(posedge clock_i);
			@(negedge clock_i);
			chk({31'h0, tok}, {31'h0, open | ~&v}, "tbl_ok");
		end
		@(posedge clock_i);
		tbl_req <= 3'h0;
	endtask

	task automatic results;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Answers come back in request order
	always @(posedge clock_i) begin
		if (psel && penable && pready === 1'b1) begin
			e = exp_q.pop_front();
			chk({31'h0, pslverr}, {31'h0, e[32]}, "pslverr");
			if (e[33]) chk(prdata, e[31:0], "prdata");
		end
	end

	initial begin
		#200000;
		err_count++;
		results;
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (16) @(posedge clock_i);
		sys_rst_i <= 1'b0;
		rd(`ADDR_SECURITY, 32'hFF, 1'b0);
		rd(`ADDR_MAKER_ID, {24'h0, `MAKER_ID_VAL}, 1'b0);
		rd(`ADDR_PART_ID, {24'h0, `PART_ID_VAL}, 1'b0);
		wr(`ADDR_PART_ID, 32'h0, 1'b1);
		rd(12'h020, 32'h0, 1'b1);
		$display("test identity done");
		wr(`ADDR_CONTROL, 32'h1, 1'b0);
		rd(`ADDR_SECURITY, 32'h0, 1'b1);
		rd(`ADDR_PART_ID, 32'h0, 1'b1);
		wr(`ADDR_PROG_CMD, 32'h014D, 1'b0);
		wr(`ADDR_PROG_CMD, 32'h01FF, 1'b0);
		wr(`ADDR_CONTROL, 32'h0, 1'b0);
		wr(`ADDR_PROG_CMD, 32'h0100, 1'b1);
		rd(`ADDR_SECURITY, 32'h4D, 1'b0);
		$display("test one way bits done");
		foreach (cases[i]) reboot(cases[i][3:1], cases[i][0]);
		chk({31'h0, clkhi}, 32'h0, "clk_range");
		tbl(1'b0);
		$display("test boot and table done");
		upd_req <= 1'b1;
		@(posedge clock_i);
		upd_req <= 1'b0;
		repeat (12) @(posedge clock_i);
		rd(`ADDR_CONTROL, 32'h1 << `CTL_UPD_DONE_BIT, 1'b0);
		chk({31'h0, hold}, 32'h0, "cpu_hold");
		$display("test loader update done");
		wr(`ADDR_CONTROL, 32'h1, 1'b0);
		wr(`ADDR_PROG_CMD, 32'h0200, 1'b0);
		wr(`ADDR_CONTROL, 32'h0, 1'b0);
		rd(`ADDR_SECURITY, 32'hFF, 1'b0);
		reboot(3'h0, 1'b0);
		tbl(1'b1);
		$display("test erase done");
		wr(`ADDR_CONTROL, 32'h1, 1'b0);
		wr(`ADDR_PROG_CMD, 32'h01FE, 1'b0);
		wr(`ADDR_CONTROL, 32'h0, 1'b0);
		rd(`ADDR_SECURITY, 32'h0, 1'b1);
		rd(`ADDR_MAKER_ID, 32'h0, 1'b1);
		chk({31'h0, acc_ok}, 32'h0, "flash_access_ok");
		$display("test lock done");
		results;
	end
endmodule // test_flash_security_option_bits

// [hdl/flash_security_map.svh]
`ifndef FLASH_SECURITY_MAP_SVH
`define FLASH_SECURITY_MAP_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define ADDR_SECURITY     12'h000
`define ADDR_MAKER_ID     12'h004
`define ADDR_PART_ID      12'h008
`define ADDR_CONTROL      12'h00C
`define ADDR_STATUS       12'h010
`define ADDR_PROG_CMD     12'h014

// ----------------------------------------------------------------
// Security byte fields and reset value
// ----------------------------------------------------------------
`define SEC_RESET         8'hFF
`define SEC_LOCK_BIT      0
`define SEC_TBL_BIT       1
`define SEC_PAIR_BIT      4
`define SEC_SINGLE_BIT    5
`define SEC_CLKRNG_BIT    7

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define CTL_PROG_MODE_BIT 0
`define CTL_IDLE_BIT      1
`define CTL_UPD_DONE_BIT  2

// ----------------------------------------------------------------
// Writer command codes and chip control value
// ----------------------------------------------------------------
`define CMD_PROGRAM       8'h01
`define CMD_ERASE_ALL     8'h02
`define CHIP_CTL_LDUPD    8'h01

// ----------------------------------------------------------------
// Identification values (arbitrary neutral values)
// ----------------------------------------------------------------
`define MAKER_ID_VAL      8'h5A
`define PART_ID_VAL       8'hC3

`endif

// [hdl/flash_security_option_bits.sv]
// What this block does
// - Security bits only go from one to zero; only erase-all restores FFh.
// - Special setting registers are denied while programming mode is on.
// - Maker and part identification registers are fixed read-only values.
// - A cleared lock bit blocks all access to flash and special registers.
// - With bit 1 low, a table read fetched externally gets external data.
// - A table read from internal space may always read internal memory.
// - With bit 1 high, table reads are never restricted.
// - With bit 4 low, reset plus both port-2 reboot pins low boots loader.
// - With bit 5 low, reset plus the port-4 reboot pin low boots loader.
// - After a loader update the CPU resumes application code, no reset.
// - External reset boots application flash unless a reboot pin forces it.
//
// Design decisions made here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps

`include "flash_security_map.svh"

module flash_security_option_bits
	import flash_security_pkg::*;
(
	// Clock and reset
	input  wire logic        clock_i,
	input  wire logic        sys_rst_i,
	// APB slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// External reset and reboot pins
	input  wire logic        ext_rst_i,
	input  wire logic        reboot_pin_pair_low_i,
	input  wire logic        reboot_pin_pair_high_i,
	input  wire logic        reboot_single_pin_i,
	// CPU core side
	input  wire logic [7:0]  chip_program_control_i,
	input  wire logic        cpu_idle_i,
	input  wire logic        fetch_external_i,
	input  wire logic        tbl_read_i,
	input  wire logic        tbl_addr_internal_i,
	// Protection and boot results
	output logic             tbl_internal_ok_o,
	output logic             flash_access_ok_o,
	output logic             boot_loader_o,
	output logic             cpu_hold_o,
	output logic             clk_range_high_o
);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [3:0] pin_meta_ff;
	logic [3:0] pin_sync_ff;
	logic [3:0] pin_raw;

	assign pin_raw = {ext_rst_i, reboot_single_pin_i,
		reboot_pin_pair_high_i, reboot_pin_pair_low_i};

	// Two flops per pin; only the second stage feeds logic
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pin_meta_ff <= 4'h0;
			pin_sync_ff <= 4'h0;
		end else begin
			pin_meta_ff <= pin_raw;
			pin_sync_ff <= pin_meta_ff;
		end
	end

	logic rst_s;
	logic pair_lo_s;
	logic pair_hi_s;
	logic single_s;

	assign pair_lo_s = pin_sync_ff[0];
	assign pair_hi_s = pin_sync_ff[1];
	assign single_s  = pin_sync_ff[2];
	assign rst_s     = pin_sync_ff[3];

	// ----------------------------------------------------------------
	// Security byte storage
	// ----------------------------------------------------------------
	logic [7:0] sec_byte_ff;
	logic [7:0] sec_live_ff;
	logic       prog_mode_ff;
	logic       upd_done_ff;
	logic [7:0] last_cmd_ff;

	logic apb_setup;
	logic apb_wr;
	logic locked;
	logic special_deny;
	logic addr_ok;

	assign apb_setup = psel_i && !penable_i;
	assign apb_wr    = psel_i && penable_i && pwrite_i;
	// Live lock bit; once cleared, only an erase-all makes registers reachable again
	assign locked       = !sec_live_ff[`SEC_LOCK_BIT];
	assign special_deny = prog_mode_ff || locked;

	// Writer command: program ANDs bits low, erase-all restores ones
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			sec_live_ff <= `SEC_RESET;
		end else if (apb_wr && paddr_i == `ADDR_PROG_CMD && prog_mode_ff)
		begin
			if (pwdata_i[15:8] == `CMD_ERASE_ALL) begin
				sec_live_ff <= `SEC_RESET;
			end else if (pwdata_i[15:8] == `CMD_PROGRAM && !locked) begin
				sec_live_ff <= sec_live_ff & pwdata_i[7:0];
			end
		end
	end

	// Last accepted command code, for status readback
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			last_cmd_ff <= 8'h00;
		end else if (apb_wr && paddr_i == `ADDR_PROG_CMD && prog_mode_ff)
		begin
			last_cmd_ff <= pwdata_i[15:8];
		end
	end

	// Programming mode switch, driven by the writer
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			prog_mode_ff <= 1'b0;
		end else if (apb_wr && paddr_i == `ADDR_CONTROL) begin
			prog_mode_ff <= pwdata_i[`CTL_PROG_MODE_BIT];
		end
	end

	// ----------------------------------------------------------------
	// Reset-time latch and boot decision
	// ----------------------------------------------------------------
	logic pair_req;
	logic single_req;
	logic boot_loader_ff;
	logic cpu_hold_ff;

	// Pins sampled while reset is high, qualified by the enables
	assign pair_req   = !sec_live_ff[`SEC_PAIR_BIT] && !pair_lo_s
		&& !pair_hi_s;
	assign single_req = !sec_live_ff[`SEC_SINGLE_BIT] && !single_s;

	// Snapshot of the option byte taken while reset is held
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			sec_byte_ff <= `SEC_RESET;
		end else if (rst_s) begin
			sec_byte_ff <= sec_live_ff;
		end
	end

	// Boot source chosen during reset, default application flash
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			boot_loader_ff <= 1'b0;
		end else if (rst_s) begin
			boot_loader_ff <= pair_req || single_req;
		end
	end

	// CPU held while external reset stands, so the snapshot is stable
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cpu_hold_ff <= 1'b1;
		end else begin
			cpu_hold_ff <= rst_s;
		end
	end

	// ----------------------------------------------------------------
	// Loader update from application flash
	// ----------------------------------------------------------------
	upd_state_type upd_state_ff;

	// Idle with 01h in chip control means update in place, then resume
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			upd_state_ff <= UPD_RUN;
		end else begin
			case (upd_state_ff)
				UPD_RUN: begin
					if (cpu_idle_i && !boot_loader_ff &&
						chip_program_control_i == `CHIP_CTL_LDUPD) begin
						upd_state_ff <= UPD_IDLE;
					end
				end
				UPD_IDLE: begin
					if (!cpu_idle_i) begin
						upd_state_ff <= UPD_RESUME;
					end
				end
				UPD_RESUME: begin
					upd_state_ff <= UPD_RUN;
				end
				default: begin
					upd_state_ff <= UPD_RUN;
				end
			endcase
		end
	end

	// Sticky done flag; a new completion wins over a clear
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			upd_done_ff <= 1'b0;
		end else if (upd_state_ff == UPD_RESUME) begin
			upd_done_ff <= 1'b1;
		end else if (apb_wr && paddr_i == `ADDR_CONTROL &&
			pwdata_i[`CTL_UPD_DONE_BIT]) begin
			upd_done_ff <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Table-read gating and access outputs
	// ----------------------------------------------------------------
	logic tbl_ok;

	// Only an external fetch with bit 1 low loses internal reach
	assign tbl_ok = sec_byte_ff[`SEC_TBL_BIT]
		|| !fetch_external_i
		|| !tbl_addr_internal_i;

	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			tbl_internal_ok_o <= 1'b1;
			flash_access_ok_o <= 1'b0;
			boot_loader_o     <= 1'b0;
			cpu_hold_o        <= 1'b1;
			clk_range_high_o  <= 1'b1;
		end else begin
			tbl_internal_ok_o <= !tbl_read_i || tbl_ok;
			flash_access_ok_o <= !locked;
			boot_loader_o     <= boot_loader_ff;
			cpu_hold_o        <= cpu_hold_ff;
			clk_range_high_o  <= sec_byte_ff[`SEC_CLKRNG_BIT];
		end
	end

	// ----------------------------------------------------------------
	// APB read path, no wait states
	// ----------------------------------------------------------------
	logic [31:0] rd_val;
	logic        rd_err;

	assign addr_ok = paddr_i == `ADDR_SECURITY || paddr_i == `ADDR_MAKER_ID
		|| paddr_i == `ADDR_PART_ID || paddr_i == `ADDR_CONTROL
		|| paddr_i == `ADDR_STATUS || paddr_i == `ADDR_PROG_CMD;

	// Decode read data; identification values are constants
	always_comb begin
		rd_val = 32'h0000_0000;
		rd_err = 1'b0;
		case (paddr_i)
			`ADDR_SECURITY: begin
				rd_val = {24'h00_0000, sec_live_ff};
				rd_err = special_deny;
			end
			`ADDR_MAKER_ID: begin
				rd_val = {24'h00_0000, `MAKER_ID_VAL};
				rd_err = special_deny;
			end
			`ADDR_PART_ID: begin
				rd_val = {24'h00_0000, `PART_ID_VAL};
				rd_err = special_deny;
			end
			`ADDR_CONTROL: begin
				rd_val = {29'h0000_0000, upd_done_ff, 1'b0, prog_mode_ff};
			end
			`ADDR_STATUS: begin
				rd_val = {16'h0000, last_cmd_ff, 4'h0, cpu_hold_ff,
					locked, boot_loader_ff, upd_state_ff != UPD_RUN};
			end
			`ADDR_PROG_CMD: begin
				rd_val = 32'h0000_0000;
			end
			default: begin
				rd_err = 1'b1;
			end
		endcase
	end

	// Writes to id or security words are refused; commands need prog mode
	logic wr_err;
	assign wr_err = !addr_ok || paddr_i == `ADDR_SECURITY
		|| paddr_i == `ADDR_MAKER_ID || paddr_i == `ADDR_PART_ID
		|| paddr_i == `ADDR_STATUS
		|| (paddr_i == `ADDR_PROG_CMD && !prog_mode_ff);

	// Answer registered in setup, presented in the first access cycle
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			prdata_o  <= 32'h0000_0000;
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
		end else if (apb_setup) begin
			pready_o  <= 1'b1;
			prdata_o  <= (pwrite_i || rd_err) ? 32'h0000_0000 : rd_val;
			pslverr_o <= pwrite_i ? wr_err : rd_err;
		end else begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
		end
	end

endmodule // flash_security_option_bits

// [hdl/flash_security_pkg.sv]
package flash_security_pkg;

	// Boot source chosen at reset
	typedef enum logic {
		BOOT_APP,
		BOOT_LOADER
	} boot_src_type;

	// Loader flash update sequencing from application flash
	typedef enum logic [1:0] {
		UPD_RUN,
		UPD_IDLE,
		UPD_RESUME
	} upd_state_type;

endpackage
